//--- pem_map.vh
`ifndef PEM_MAP_VH
`define PEM_MAP_VH

// Exception numbers
`define PEM_NUM_RESET 8'h01
`define PEM_NUM_NMI 8'h02
`define PEM_NUM_SEVERE 8'h03
`define PEM_NUM_MPF 8'h04
`define PEM_NUM_BEF 8'h05
`define PEM_NUM_IUF 8'h06
`define PEM_NUM_SVC 8'h0b
`define PEM_NUM_PENDABLE_SYSTEM_SERVICE 8'h0e
`define PEM_NUM_SYSTEM_TICK_EXCEPTION 8'h0f
`define PEM_NUM_IRQ0 8'h10
`define PEM_NUM_W 8

// Vector offsets of the fixed table entries
`define PEM_VEC_RESET 32'h00000004
`define PEM_VEC_NMI 32'h00000008
`define PEM_VEC_SEVERE 32'h0000000c
`define PEM_VEC_MPF 32'h00000010
`define PEM_VEC_BEF 32'h00000014
`define PEM_VEC_IUF 32'h00000018
`define PEM_VEC_SVC 32'h0000002c
`define PEM_VEC_SHIFT 2

// Priority field and urgency rank (rank = priority + 4)
`define PEM_PRIO_W 8
`define PEM_RANK_W 10
`define PEM_RANK_NMI 10'h002
`define PEM_RANK_SEVERE 10'h003
`define PEM_RANK_BIAS 10'h004
`define PEM_RANK_NONE 10'h3ff

// Index of each configurable system exception in i_sys_* ports
`define PEM_SYS_MPF 0
`define PEM_SYS_BEF 1
`define PEM_SYS_IUF 2
`define PEM_SYS_SVC 3
`define PEM_SYS_PENDABLE_SYSTEM_SERVICE 4
`define PEM_SYS_SYSTEM_TICK_EXCEPTION 5
`define PEM_SYS_N 6

`endif

//--- pem_exception_unit.v
`timescale 1ns/100ps
`default_nettype none
`include "pem_map.vh"

// Contract
// RULE1 - Each source inactive, pending, active, or both
// RULE2 - Line or software request makes interrupt pending
// RULE3 - Nested handlers both stay active
// RULE4 - Reset: always enabled, priority -3, offset 4
// RULE5 - Halt in reset, fetch reset vector after
// RULE6 - Start privileged in thread mode
// RULE7 - Non-maskable interrupt: priority -2, offset 8
// RULE8 - Severe fault for unmanageable faults, priority -1
// RULE9 - Protection fault incl. no-execute fetch, offset 0x10
// RULE10 - Bus error fault, precise sync, offset 0x14
// RULE11 - Usage fault synchronous, offset 0x18
// RULE12 - Unaligned and divide-zero faults only when enabled
// RULE13 - Supervisor call is number 11, offset 0x2c
// RULE14 - Pendable system service by software request
// RULE15 - Tick exception on timer zero or software
// RULE16 - Interrupts are asynchronous
// RULE17 - Async exceptions may allow one more instruction
// RULE18 - Configurable exceptions individually disabled
// RULE19 - Lower priority value means more urgent
// RULE20 - Configurable priorities reset to zero
// RULE21 - Equal priority: lowest number first
// RULE22 - Equal priority never preempts, only pends
// RULE23 - Interrupt number minus sixteen, vector four times
module pem_exception_unit #(
  parameter N_IRQ = 8
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [N_IRQ-1:0] i_irq_line,
  input wire [N_IRQ-1:0] i_sw_irq_set,
  input wire [N_IRQ-1:0] i_irq_enable,
  input wire [N_IRQ*`PEM_PRIO_W-1:0] i_irq_prio,
  input wire i_nmi_line,
  input wire i_sw_nmi_set,
  input wire [`PEM_SYS_N-1:0] i_sys_enable,
  input wire [`PEM_SYS_N*`PEM_PRIO_W-1:0] i_sys_prio,
  input wire i_exc_proc_err,
  input wire i_mpu_violation,
  input wire i_fetch_no_execute,
  input wire i_bus_err_precise,
  input wire i_bus_err_imprecise,
  input wire i_undef_instr,
  input wire i_unaligned_illegal,
  input wire i_invalid_state,
  input wire i_exc_return_err,
  input wire i_unaligned_access,
  input wire i_div_zero,
  input wire i_unaligned_report_en,
  input wire i_div_zero_report_en,
  input wire i_supervisor_call_instruction,
  input wire i_pendable_system_service_set,
  input wire i_system_tick_exception_zero,
  input wire i_system_tick_exception_set,
  input wire [31:0] i_vtor_base,
  input wire i_take_ready,
  input wire i_exc_return,
  input wire [`PEM_NUM_W-1:0] i_ret_num,
  input wire i_drop_priv,
  output reg o_halt,
  output reg o_boot_fetch,
  output reg [31:0] o_boot_addr,
  output reg o_take,
  output reg [`PEM_NUM_W-1:0] o_take_num,
  output reg [`PEM_NUM_W:0] o_take_irq_num,
  output reg [31:0] o_take_vector,
  output reg o_take_sync,
  output reg o_handler_mode,
  output reg o_privileged,
  output wire [2*(N_IRQ+16)-1:0] o_exc_state
);

  // Sixteen system slots come first, then the interrupts
  localparam NX = N_IRQ + `PEM_NUM_IRQ0;
  localparam PW = `PEM_PRIO_W;
  localparam RW = `PEM_RANK_W;

  // Two-flop synchronisers plus an edge stage for pin inputs
  reg [N_IRQ-1:0] irq_s1;
  reg [N_IRQ-1:0] irq_s2;
  reg [N_IRQ-1:0] irq_s3;
  reg nmi_s1;
  reg nmi_s2;
  reg nmi_s3;
  // Chain clears in reset so no false edge follows release
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_s1 <= {N_IRQ{1'b0}};
      irq_s2 <= {N_IRQ{1'b0}};
      irq_s3 <= {N_IRQ{1'b0}};
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
      nmi_s3 <= 1'b0;
    end else begin
      irq_s1 <= i_irq_line;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      nmi_s1 <= i_nmi_line;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
    end
  end

  // Edges, not levels, so a held line does not re-pend forever
  wire [N_IRQ-1:0] irq_rise = irq_s2 & ~irq_s3;
  wire nmi_rise = nmi_s2 & ~nmi_s3;

  // Fault causes
  wire mpf_req = i_mpu_violation | i_fetch_no_execute; // [RULE9]
  wire bef_req = i_bus_err_precise | i_bus_err_imprecise; // [RULE10]
  wire iuf_req = i_undef_instr | i_unaligned_illegal |
                 i_invalid_state | i_exc_return_err | // [RULE11]
                 (i_unaligned_access & i_unaligned_report_en) |
                 (i_div_zero & i_div_zero_report_en); // [RULE12]

  // A disabled fault handler cannot take it: escalate to severe
  wire mpf_en = i_sys_enable[`PEM_SYS_MPF];
  wire bef_en = i_sys_enable[`PEM_SYS_BEF];
  wire iuf_en = i_sys_enable[`PEM_SYS_IUF];
  // Severe has no enable, so escalation always lands
  wire sev_req = i_exc_proc_err | (mpf_req & ~mpf_en) |
                 (bef_req & ~bef_en) | (iuf_req & ~iuf_en); // [RULE8]

  // Imprecise bus error makes its activation asynchronous
  reg bef_async;
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      bef_async <= 1'b0;
    end else if (bef_req & bef_en) begin
      bef_async <= i_bus_err_imprecise & ~i_bus_err_precise; // [RULE10]
    end
  end

  // Flat per-slot views for the arbiter
  wire [NX-1:0] pend_v;
  wire [NX-1:0] act_v;
  wire [NX-1:0] en_v;
  wire [NX*RW-1:0] rank_v;

  // Arbiter results, read back by every state slice
  reg take;
  reg [`PEM_NUM_W-1:0] win_num;
  reg [RW-1:0] win_rank;

  // Per-exception request, enable, rank and two state bits
  genvar n;
  generate
    for (n = 0; n < NX; n = n + 1) begin : g_exc
      // Request, enable and rank are chosen per slot below
      wire req;
      wire en;
      wire [RW-1:0] rk;
      reg pend;
      reg act;
      if (n == `PEM_NUM_NMI) begin : g_nmi
        // Pin edge or software; no enable, fixed rank
        assign req = nmi_rise | i_sw_nmi_set;
        assign en = 1'b1; // [RULE7]
        assign rk = `PEM_RANK_NMI; // [RULE7]
      end else if (n == `PEM_NUM_SEVERE) begin : g_sev
        // Always enabled so escalated faults land here
        assign req = sev_req;
        assign en = 1'b1; // [RULE18]
        assign rk = `PEM_RANK_SEVERE; // [RULE8]
      end else if (n == `PEM_NUM_MPF) begin : g_mpf
        // Zero, the default, is the most urgent configurable rank
        assign req = mpf_req & mpf_en;
        assign en = mpf_en;
        assign rk = {2'b00, i_sys_prio[`PEM_SYS_MPF*PW +: PW]} +
                    `PEM_RANK_BIAS; // [RULE20]
      end else if (n == `PEM_NUM_BEF) begin : g_bef
        // Pends only when enabled; otherwise severe takes it
        assign req = bef_req & bef_en;
        assign en = bef_en;
        assign rk = {2'b00, i_sys_prio[`PEM_SYS_BEF*PW +: PW]} +
                    `PEM_RANK_BIAS;
      end else if (n == `PEM_NUM_IUF) begin : g_iuf
        // Causes already filtered by the report enables
        assign req = iuf_req & iuf_en;
        assign en = iuf_en;
        assign rk = {2'b00, i_sys_prio[`PEM_SYS_IUF*PW +: PW]} +
                    `PEM_RANK_BIAS;
      end else if (n == `PEM_NUM_SVC) begin : g_svc
        // Raised in step with the call instruction
        assign req = i_supervisor_call_instruction; // [RULE13]
        assign en = i_sys_enable[`PEM_SYS_SVC];
        assign rk = {2'b00, i_sys_prio[`PEM_SYS_SVC*PW +: PW]} +
                    `PEM_RANK_BIAS;
      end else if (n == `PEM_NUM_PENDABLE_SYSTEM_SERVICE) begin : g_psv
        // Software-only request, meant for deferred switching
        assign req = i_pendable_system_service_set; // [RULE14]
        assign en = i_sys_enable[`PEM_SYS_PENDABLE_SYSTEM_SERVICE];
        assign rk = {2'b00, i_sys_prio[`PEM_SYS_PENDABLE_SYSTEM_SERVICE*PW +: PW]} +
                    `PEM_RANK_BIAS;
      end else if (n == `PEM_NUM_SYSTEM_TICK_EXCEPTION) begin : g_tick
        // Timer reaching zero, or software
        assign req = i_system_tick_exception_zero | i_system_tick_exception_set; // [RULE15]
        assign en = i_sys_enable[`PEM_SYS_SYSTEM_TICK_EXCEPTION];
        assign rk = {2'b00, i_sys_prio[`PEM_SYS_SYSTEM_TICK_EXCEPTION*PW +: PW]} +
                    `PEM_RANK_BIAS;
      end else if (n >= `PEM_NUM_IRQ0) begin : g_irq
        // Interrupt k sits at slot k plus sixteen
        localparam K = n - `PEM_NUM_IRQ0;
        assign req = irq_rise[K] | i_sw_irq_set[K]; // [RULE2]
        assign en = i_irq_enable[K]; // [RULE18]
        assign rk = {2'b00, i_irq_prio[K*PW +: PW]} +
                    `PEM_RANK_BIAS; // [RULE19]
      end else begin : g_none
        // Reserved numbers: never pend, never win
        assign req = 1'b0;
        assign en = 1'b0;
        assign rk = `PEM_RANK_NONE;
      end

      // Set wins over the clear done by taking the exception
      always @(posedge i_clk) begin
        if (i_sys_rst) begin
          pend <= 1'b0;
          act <= 1'b0;
        end else begin
          if (take && win_num == n) begin
            act <= 1'b1; // [RULE3]
            pend <= req; // [RULE1]
          end else begin
            if (req) begin
              pend <= 1'b1; // [RULE1]
            end
            if (i_exc_return && i_ret_num == n) begin
              act <= 1'b0;
            end
          end
        end
      end

      // Export this slot's bits to the flat buses
      assign pend_v[n] = pend;
      assign act_v[n] = act;
      assign en_v[n] = en;
      assign rank_v[n*RW +: RW] = rk;
      assign o_exc_state[2*n +: 2] = {act, pend}; // [RULE1]
    end
  endgenerate

  // Arbiter: scan downward so ties go to the lowest number
  integer i;
  reg found;
  reg [RW-1:0] cur_rank;
  always @* begin
    found = 1'b0;
    win_num = {`PEM_NUM_W{1'b0}};
    win_rank = `PEM_RANK_NONE;
    cur_rank = `PEM_RANK_NONE;
    // Slots 0 and 1 never pend; reset acts as a halt instead
    for (i = NX - 1; i > 1; i = i - 1) begin
      if (pend_v[i] && en_v[i] &&
          rank_v[i*RW +: RW] <= win_rank) begin // [RULE21]
        found = 1'b1;
        win_num = i[`PEM_NUM_W-1:0];
        win_rank = rank_v[i*RW +: RW]; // [RULE19]
      end
      if (act_v[i] && rank_v[i*RW +: RW] < cur_rank) begin
        cur_rank = rank_v[i*RW +: RW];
      end
    end
    // Only a strictly more urgent one preempts a running handler
    take = found & i_take_ready & ~o_halt &
           (win_rank < cur_rank); // [RULE22]
  end

  // Which exceptions activate in step with the instruction stream
  reg win_sync;
  always @* begin
    // Severe fault reported as synchronous by choice
    case (win_num)
      `PEM_NUM_SEVERE: win_sync = 1'b1;
      `PEM_NUM_MPF: win_sync = 1'b1; // [RULE9]
      `PEM_NUM_BEF: win_sync = ~bef_async; // [RULE10]
      `PEM_NUM_IUF: win_sync = 1'b1; // [RULE11]
      `PEM_NUM_SVC: win_sync = 1'b1; // [RULE13]
      default: win_sync = 1'b0; // [RULE16]
    endcase
  end

  // Entry report to the pipeline, one cycle after the decision
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_take <= 1'b0;
      o_take_num <= {`PEM_NUM_W{1'b0}};
      o_take_irq_num <= {(`PEM_NUM_W+1){1'b0}};
      o_take_vector <= 32'h00000000;
      o_take_sync <= 1'b0;
    end else begin
      // High only in the cycle after a decision
      o_take <= take;
      if (take) begin
        o_take_num <= win_num;
        o_take_irq_num <= {1'b0, win_num} -
                          {1'b0, `PEM_NUM_IRQ0}; // [RULE23]
        o_take_vector <= i_vtor_base +
          {22'h000000, win_num, 2'b00}; // [RULE23]
        // Low means the pipeline may retire one more first
        o_take_sync <= win_sync; // [RULE17]
      end
    end
  end

  // Reset halts; first edge after release starts at the vector
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_halt <= 1'b1; // [RULE5]
      o_boot_fetch <= 1'b0;
      o_boot_addr <= 32'h00000000;
    end else begin
      o_halt <= 1'b0;
      // One cycle only, as o_halt clears on this same edge
      o_boot_fetch <= o_halt; // [RULE4] [RULE5]
      if (o_halt) begin
        o_boot_addr <= i_vtor_base + `PEM_VEC_RESET; // [RULE4]
      end
    end
  end

  // Mode and privilege; thread mode privileged out of reset
  reg thread_priv;
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      thread_priv <= 1'b1; // [RULE6]
      o_handler_mode <= 1'b0; // [RULE6]
      o_privileged <= 1'b1;
    end else begin
      if (i_drop_priv) begin
        thread_priv <= 1'b0;
      end
      // Lags the active bits by one edge; pipeline must allow it
      o_handler_mode <= |act_v;
      // Handlers always run privileged
      o_privileged <= (|act_v) | (thread_priv & ~i_drop_priv);
    end
  end

endmodule // pem_exception_unit
`default_nettype wire

//--- pem_checker.sv
`timescale 1ns/100ps
`default_nettype none
// Boot, entry and vector relations seen at the unit's ports
module pem_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [31:0] i_vtor_base,
  input wire logic o_halt,
  input wire logic o_boot_fetch,
  input wire logic [31:0] o_boot_addr,
  input wire logic o_take,
  input wire logic [7:0] o_take_num,
  input wire logic [8:0] o_take_irq_num,
  input wire logic [31:0] o_take_vector,
  input wire logic o_take_sync,
  input wire logic o_handler_mode,
  input wire logic o_privileged
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // Halt must follow reset even while reset itself is high
  property p_halt; disable iff (1'b0) i_sys_rst |=> o_halt; endproperty
  a_halt: assert property (p_halt) else $error("no halt in reset");
  property p_boot; o_halt && !i_sys_rst |=> o_boot_fetch && !o_halt &&
    o_boot_addr == $past(i_vtor_base) + 32'h4; endproperty
  a_boot: assert property (p_boot) else $error("bad boot fetch");
  property p_bpulse; o_boot_fetch |=> !o_boot_fetch; endproperty
  a_bpulse: assert property (p_bpulse) else $error("long boot");
  property p_priv; o_boot_fetch |-> o_privileged && !o_handler_mode;
  endproperty
  a_priv: assert property (p_priv) else $error("bad start mode");
  property p_notake; o_halt |=> !o_take; endproperty
  a_notake: assert property (p_notake) else $error("take in halt");
  // Table entry is four bytes per exception number
  property p_vec; o_take |->
    o_take_vector == i_vtor_base + {22'h0, o_take_num, 2'b00}; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_irqn; o_take |->
    o_take_irq_num == {1'b0, o_take_num} - 9'h010; endproperty
  a_irqn: assert property (p_irqn) else $error("bad irq number");
  // Handler mode is registered from the active bits, one cycle late
  property p_svc; o_take && o_take_num == 8'h0b |->
    o_take_sync ##1 o_handler_mode; endproperty
  a_svc: assert property (p_svc) else $error("svc not sync");
  property p_async; o_take && o_take_num >= 8'h10 |-> !o_take_sync;
  endproperty
  a_async: assert property (p_async) else $error("irq sync");
  property p_nmi; o_take && o_take_num == 8'h02 |-> !o_take_sync &&
    o_take_vector == i_vtor_base + 32'h8; endproperty
  a_nmi: assert property (p_nmi) else $error("bad nmi entry");
endmodule // pem_checker

bind pem_exception_unit pem_checker u_chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_vtor_base(i_vtor_base), .o_halt(o_halt),
  .o_boot_fetch(o_boot_fetch), .o_boot_addr(o_boot_addr), .o_take(o_take),
  .o_take_num(o_take_num), .o_take_irq_num(o_take_irq_num),
  .o_take_vector(o_take_vector), .o_take_sync(o_take_sync),
  .o_handler_mode(o_handler_mode), .o_privileged(o_privileged));
`default_nettype wire

//--- pem_pipe_model.sv
`timescale 1ns/100ps
`default_nettype none
module pem_pipe_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_mode,
  input wire logic i_take,
  input wire logic [7:0] i_take_num,
  input wire logic i_ret_req,
  output logic o_ready,
  output logic o_ret,
  output logic [7:0] o_ret_num
);
  logic [7:0] stk [0:7];
  logic [2:0] sp;
  // Mode 0 prompt, 1 every other cycle, 2 stalled; newest handler
  // returns first, as a nested stack would; number bus junk when idle
  always @(posedge i_clk) begin
    o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && !o_ready);
    o_ret <= i_ret_req;
    o_ret_num <= ~o_ret_num;
    if (i_rst) begin
      sp <= 3'h0;
      o_ready <= 1'b0;
      o_ret <= 1'b0;
    end else if (i_take) begin
      stk[sp] <= i_take_num;
      sp <= sp + 3'h1;
    end else if (i_ret_req) begin
      o_ret_num <= stk[sp - 3'h1];
      sp <= sp - 3'h1;
    end
  end
endmodule // pem_pipe_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  error_cnt++; $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  localparam logic [31:0] VTOR = 32'h20000400;
  localparam logic [127:0] NUM = 128'h020f0f0e0b0606060606060505040403;
  localparam logic [15:0] SYN = 16'h0fef;
  int error_cnt = 0;
  int samples_checked = 0;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, nmi = 1'b0, drop = 1'b0;
  logic ret_req = 1'b0, rdy, ret, halt, boot, take, tsync, hmode, priv;
  logic [15:0] flt = 16'h0;
  logic [7:0] irq_line = 8'h0, sw_irq = 8'h0, irq_en = 8'hff, ret_num, tnum;
  logic [63:0] prio = 64'h0;
  logic [47:0] sprio = 48'h0;
  logic [5:0] sen = 6'h3f;
  logic [1:0] rpt = 2'h3, mode = 2'h0;
  logic [8:0] tirq;
  logic [31:0] baddr, tvec;
  logic [47:0] st;
  always #25 i_clk = ~i_clk;
  pem_exception_unit #(.N_IRQ(8)) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_irq_line(irq_line), .i_sw_irq_set(sw_irq), .i_irq_enable(irq_en),
    .i_irq_prio(prio), .i_nmi_line(nmi), .i_sw_nmi_set(flt[15]),
    .i_sys_enable(sen), .i_sys_prio(sprio), .i_exc_proc_err(flt[0]),
    .i_mpu_violation(flt[1]), .i_fetch_no_execute(flt[2]),
    .i_bus_err_precise(flt[3]), .i_bus_err_imprecise(flt[4]),
    .i_undef_instr(flt[5]), .i_unaligned_illegal(flt[6]),
    .i_invalid_state(flt[7]), .i_exc_return_err(flt[8]),
    .i_unaligned_access(flt[9]), .i_div_zero(flt[10]),
    .i_unaligned_report_en(rpt[0]), .i_div_zero_report_en(rpt[1]),
    .i_supervisor_call_instruction(flt[11]), .i_pendable_system_service_set(flt[12]),
    .i_system_tick_exception_zero(flt[13]), .i_system_tick_exception_set(flt[14]), .i_vtor_base(VTOR),
    .i_take_ready(rdy), .i_exc_return(ret), .i_ret_num(ret_num),
    .i_drop_priv(drop), .o_halt(halt), .o_boot_fetch(boot),
    .o_boot_addr(baddr), .o_take(take), .o_take_num(tnum),
    .o_take_irq_num(tirq), .o_take_vector(tvec), .o_take_sync(tsync),
    .o_handler_mode(hmode), .o_privileged(priv), .o_exc_state(st));
  pem_pipe_model pipe_u (.i_clk(i_clk), .i_rst(i_sys_rst), .i_mode(mode),
    .i_take(take), .i_take_num(tnum), .i_ret_req(ret_req), .o_ready(rdy),
    .o_ret(ret), .o_ret_num(ret_num));

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for one entry, then its number, vector and kind
  task automatic tk(input logic [7:0] n, input logic s);
    int k;
    for (k = 0; k < 80; k++) begin
      @(negedge i_clk);
      if (take === 1'b1) break;
    end
    if (k == 80) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, 1'b0, 1'b1);
      summarize();
    end
    `CHK(tnum, n)
    `CHK(tvec, VTOR + {22'h0, n, 2'b00})
    `CHK(tirq, {1'b0, n} - 9'h010)
    `CHK(tsync, s)
  endtask
  task automatic pl(input logic [15:0] m);
    @(posedge i_clk) flt <= m;
    @(posedge i_clk) flt <= 16'h0;
  endtask
  task automatic rt();
    @(posedge i_clk) ret_req <= 1'b1;
    @(posedge i_clk) ret_req <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic t_reset();
    @(posedge i_clk) i_sys_rst <= 1'b1;
    repeat (10) @(posedge i_clk);
    @(negedge i_clk) `CHK(halt, 1'b1)
    `CHK(priv, 1'b1)
    `CHK(st, 48'h0)
    @(posedge i_clk) i_sys_rst <= 1'b0;
    @(posedge i_clk);
    @(negedge i_clk) `CHK(boot, 1'b1)
    `CHK(baddr, VTOR + 32'h4)
    `CHK(hmode, 1'b0)
    repeat (3) @(posedge i_clk);
    $display("test reset done");
  endtask
  // Each of the 16 flt sources once, alternating prompt and slow pipeline
  task automatic t_srcs();
    for (int i = 0; i < 16; i++) begin
      mode <= {1'b0, i[0]};
      pl(16'h1 << i);
      tk(NUM[8*i+:8], SYN[i]);
      rt();
    end
    mode <= 2'h0;
    $display("test sources done");
  endtask
  task automatic t_report();
    rpt <= 2'h0;
    pl(16'h0600);
    repeat (4) @(negedge i_clk);
    `CHK({st[13:12], hmode}, 3'h0)
    rpt <= 2'h3;
    $display("test report done");
  endtask
  task automatic t_dis();
    sen <= 6'h1e;
    pl(16'h4002);
    tk(8'h03, 1'b1);
    rt();
    @(negedge i_clk) `CHK({st[31:30], hmode}, 3'h2)
    @(posedge i_clk) sen <= 6'h3f;
    tk(8'h0f, 1'b0);
    rt();
    irq_en[4] <= 1'b0;
    @(posedge i_clk) sw_irq <= 8'h10;
    @(posedge i_clk) sw_irq <= 8'h00;
    repeat (4) @(negedge i_clk);
    `CHK({st[41:40], hmode}, 3'h2)
    @(posedge i_clk) irq_en[4] <= 1'b1;
    tk(8'h14, 1'b0);
    rt();
    nmi <= 1'b1;
    tk(8'h02, 1'b0);
    @(posedge i_clk) nmi <= 1'b0;
    rt();
    $display("test disable done");
  endtask
  // Priority order, equal-priority hold-off and nesting
  task automatic t_prio();
    mode <= 2'h2;
    prio <= 64'h0000000000010102;
    @(posedge i_clk) sw_irq <= 8'h07;
    @(posedge i_clk) sw_irq <= 8'h00;
    repeat (3) @(negedge i_clk);
    `CHK({st[36], st[34], st[32]}, 3'h7)
    mode <= 2'h0;
    tk(8'h11, 1'b0);
    repeat (5) @(negedge i_clk);
    `CHK({take, st[37:36]}, 3'h1)
    irq_line[3] <= 1'b1;
    tk(8'h13, 1'b0);
    `CHK({st[39], st[35]}, 2'h3)
    irq_line[3] <= 1'b0;
    rt();
    rt();
    tk(8'h12, 1'b0);
    rt();
    tk(8'h10, 1'b0);
    rt();
    @(negedge i_clk) `CHK(hmode, 1'b0)
    $display("test priority done");
  endtask

  // Configured system priorities override the number order
  task automatic t_sys();
    @(posedge i_clk) sprio <= 48'h000001000000;
    pl(16'h1800);
    tk(8'h0e, 1'b0);
    rt();
    tk(8'h0b, 1'b1);
    rt();
    sprio <= 48'h0;
    $display("test system priority done");
  endtask

  initial begin
    t_reset();
    t_srcs();
    t_report();
    t_dis();
    t_prio();
    t_sys();
    @(posedge i_clk) drop <= 1'b1;
    @(posedge i_clk) drop <= 1'b0;
    @(negedge i_clk) `CHK(priv, 1'b0)
    t_reset();
    summarize();
  end
endmodule // testbench
`default_nettype wire
